// file: pkg/fifo_port_pkg.sv
/*
 * Shared constants for the byte-wide FIFO host port: data width, buffer
 * depth and the idle levels of the active-low port signals.
 * Assumes both ends run on one core clock, 100 MHz.
 */
package fifo_port_pkg;
    localparam int          DATA_W        = 8;
    localparam int          BUF_DEPTH     = 8;
    localparam logic        FLAG_IDLE     = 1'b1;
    localparam logic        STROBE_IDLE   = 1'b1;
    localparam logic [7:0]  DATA_RESET    = 8'h00;
    localparam int          CLK_PERIOD_NS = 10;
    // Host keeps each strobe phase longer than this, STROBE_CYC+1 cycles, so the device synchroniser sees it
    localparam int          STROBE_NS     = 40;
    localparam int          STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// file: pkg/fifo_port_if.sv
/*
 * Pin-level carrier between the port's device end and its host end.
 * The data bus is two-way; the wire level is resolved here from both enables.
 */
interface fifo_port_if;
    import fifo_port_pkg::*;
    logic              txe_n;
    logic              rxf_n;
    logic              wr_n;
    logic              rd_n;
    logic              oe_n;
    logic              port_clk;
    logic [DATA_W-1:0] dev_data_out;
    logic              dev_data_oe;
    logic [DATA_W-1:0] host_data_out;
    logic              host_data_oe;
    logic [DATA_W-1:0] port_data_lines;

    assign port_data_lines = dev_data_oe  ? dev_data_out :
                             host_data_oe ? host_data_out : DATA_RESET;

    modport device (output txe_n, output rxf_n, input wr_n, input rd_n, input oe_n,
                    output port_clk, output dev_data_out, output dev_data_oe,
                    input port_data_lines);
    modport host   (input txe_n, input rxf_n, output wr_n, output rd_n, output oe_n,
                    input port_clk, output host_data_out, output host_data_oe,
                    input port_data_lines);
endinterface

// file: rtl/byte_buffer.sv
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock, synchronous active-low reset, clock enable.
 */
module byte_buffer
    import fifo_port_pkg::*;
#(
    parameter int WIDTH = DATA_W,
    parameter int DEPTH = BUF_DEPTH
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    input  wire logic             clk_en,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;

    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];

    always_ff @(posedge core_clk) begin
        if (clk_en && push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else if (clk_en) begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // byte_buffer

// file: rtl/fifo_port_device.sv
/*
 * Device end of the byte-wide FIFO host port: synchronises host strobes,
 * stores written bytes in a transmit buffer, presents receive bytes.
 * Assumes the host end keeps its own rules; user side is valid/ready.
 */
// Summary of operation
// - Host never writes while transmit flag high
// - Flag low: write strobe pulse delivers byte
// - Host never reads while receive flag high
// - Receive flag low only with byte waiting
// - Write strobe falling edge captures data lines
// - Drive data while read strobe low only; async build keeps driving up to three cycles after rd_n rises
// - Read strobe falling edge advances receive buffer
// - Eight-bit two-way bus, flags out, strobes in
// - Output enable used only in synchronous variant
// - Port clock exists only in synchronous variant
// - Hash-marked signals are active low
module fifo_port_device
    import fifo_port_pkg::*;
#(
    parameter bit SYNC_MODE = 1'b0,
    parameter int DEPTH     = BUF_DEPTH
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    input  wire logic              clk_en,
    // Port pins
    fifo_port_if.device            port,
    // Bytes written by the host
    output logic                   tx_valid,
    input  wire logic              tx_ready,
    output logic      [DATA_W-1:0] tx_data,
    // Bytes for the host to read
    input  wire logic              rx_valid,
    output logic                   rx_ready,
    input  wire logic [DATA_W-1:0] rx_data
);
    ////////////////////////////////////////////////////////////////////////
    // Strobe synchronisers
    logic [2:0]        wr_sync;
    logic [2:0]        rd_sync;
    logic [DATA_W-1:0] wr_data_q;
    logic              tx_in_ready;
    logic              tx_out_valid;
    logic [DATA_W-1:0] tx_out_data;
    logic              rx_out_valid;
    logic [DATA_W-1:0] rx_out_data;
    logic              txe_n_q;
    logic              rxf_n_q;
    logic              dout_oe_q;
    logic [DATA_W-1:0] dout_q;
    logic              pclk_q;
    logic              tx_hold;
    logic [DATA_W-1:0] tx_hold_data;

    // Falling edges seen only on stages 1 and 2, never the first flop
    wire wr_fall = wr_sync[2] && !wr_sync[1];
    wire rd_fall = rd_sync[2] && !rd_sync[1];
    wire rd_low  = !rd_sync[1];
    // Output enable gates the bus only when built synchronous
    wire oe_ok   = SYNC_MODE ? !port.oe_n : 1'b1;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            wr_sync <= {3{STROBE_IDLE}};
            rd_sync <= {3{STROBE_IDLE}};
        end else if (clk_en) begin
            wr_sync <= {wr_sync[1:0], port.wr_n};
            rd_sync <= {rd_sync[1:0], port.rd_n};
        end
    end

    // Data sampled alongside the strobe so it lines up with the edge
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            wr_data_q <= DATA_RESET;
        end else if (clk_en && wr_sync[1]) begin
            wr_data_q <= port.port_data_lines;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit path: host writes into buffer
    byte_buffer #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_tx_buf (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .clk_en   (clk_en),
        .in_valid (wr_fall),
        .in_ready (tx_in_ready),
        .in_data  (wr_data_q),
        .out_valid(tx_out_valid),
        .out_ready(!tx_hold || tx_ready),
        .out_data (tx_out_data)
    );

    // Output stage keeps user-side outputs registered
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            tx_hold      <= 1'b0;
            tx_hold_data <= DATA_RESET;
        end else if (clk_en && (!tx_hold || tx_ready)) begin
            tx_hold      <= tx_out_valid;
            tx_hold_data <= tx_out_data;
        end
    end
    assign tx_valid = tx_hold;
    assign tx_data  = tx_hold_data;

    ////////////////////////////////////////////////////////////////////////
    // Receive path: user fills, host strobes out
    byte_buffer #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_rx_buf (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .clk_en   (clk_en),
        .in_valid (rx_valid),
        .in_ready (rx_ready),
        .in_data  (rx_data),
        .out_valid(rx_out_valid),
        .out_ready(rd_fall),
        .out_data (rx_out_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Flags, data drive, port clock
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            txe_n_q   <= FLAG_IDLE;
            rxf_n_q   <= FLAG_IDLE;
            dout_oe_q <= 1'b0;
            dout_q    <= DATA_RESET;
            pclk_q    <= 1'b0;
        end else if (clk_en) begin
            // Conservative: flag high when full and for a cycle after each write edge hides sync latency
            txe_n_q   <= !tx_in_ready || wr_fall;
            // Held high during a read so host waits for the next byte
            rxf_n_q   <= !rx_out_valid || rd_fall || rd_low;
            dout_oe_q <= rd_low && oe_ok;
            if (rd_fall || !rd_low) begin
                dout_q <= rx_out_data;
            end
            pclk_q    <= SYNC_MODE ? !pclk_q : 1'b0;
        end
    end

    // Active-low flags drive the port as-is
    assign port.txe_n        = txe_n_q;
    assign port.rxf_n        = rxf_n_q;
    assign port.dev_data_oe  = dout_oe_q;
    assign port.dev_data_out = dout_q;
    assign port.port_clk     = pclk_q;
endmodule // fifo_port_device

// file: rtl/fifo_port_host.sv
/*
 * Host end of the byte-wide FIFO host port: writes bytes while space is
 * signalled, reads bytes while data is signalled, strobes held STROBE_CYC+1 cycles.
 * Assumes the device end synchronises strobes.
 */
module fifo_port_host
    import fifo_port_pkg::*;
(
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    input  wire logic              clk_en,
    // Port pins
    fifo_port_if.host              port,
    // Bytes to send
    input  wire logic              wr_valid,
    output logic                   wr_ready,
    input  wire logic [DATA_W-1:0] wr_data,
    // Bytes received
    output logic                   rd_valid,
    output logic      [DATA_W-1:0] rd_data
);
    typedef enum logic [2:0] {IDLE, WR_HI, WR_LO, RD_LO, RD_HI} state_e;

    state_e            state;
    logic [7:0]        cnt;
    logic              wr_n_q;
    logic              rd_n_q;
    logic              oe_q;
    logic [DATA_W-1:0] dout_q;
    logic              rdv_q;
    logic [DATA_W-1:0] rdd_q;

    wire done     = (cnt == 8'(STROBE_CYC));
    wire can_wr   = !port.txe_n && wr_valid;
    wire can_rd   = !port.rxf_n;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state  <= IDLE;
            cnt    <= 8'h00;
            wr_n_q <= STROBE_IDLE;
            rd_n_q <= STROBE_IDLE;
            oe_q   <= 1'b0;
            dout_q <= DATA_RESET;
            rdv_q  <= 1'b0;
            rdd_q  <= DATA_RESET;
        end else if (clk_en) begin
            rdv_q <= 1'b0;
            cnt   <= done ? 8'h00 : cnt + 8'h01;
            unique case (state)
                IDLE: begin
                    cnt <= 8'h00;
                    if (can_rd) begin
                        state  <= RD_LO;
                        rd_n_q <= 1'b0;
                    end else if (can_wr) begin
                        // Strobe high then low: low edge stores the byte
                        state  <= WR_HI;
                        dout_q <= wr_data;
                        oe_q   <= 1'b1;
                    end
                end
                WR_HI: if (done) begin
                    state  <= WR_LO;
                    wr_n_q <= 1'b0;
                end
                WR_LO: if (done) begin
                    state  <= IDLE;
                    wr_n_q <= STROBE_IDLE;
                    oe_q   <= 1'b0;
                end
                RD_LO: if (done) begin
                    state  <= RD_HI;
                    rd_n_q <= STROBE_IDLE;
                    rdv_q  <= 1'b1;
                    rdd_q  <= port.port_data_lines;
                end
                RD_HI: if (done) begin
                    state <= IDLE;
                end
            endcase
        end
    end

    assign wr_ready           = clk_en && rst_b && (state == IDLE) && !can_rd && can_wr;
    assign port.wr_n          = wr_n_q;
    assign port.rd_n          = rd_n_q;
    assign port.oe_n          = rd_n_q;
    assign port.host_data_oe  = oe_q;
    assign port.host_data_out = dout_q;
    assign rd_valid           = rdv_q;
    assign rd_data            = rdd_q;
endmodule // fifo_port_host

// file: tb/fifo_port_assertions.sv
/*
 * Wire checker for the FIFO host port, watching both ends at once.
 * Assumes plain inputs from the interface, one clock, sync low reset.
 */
module fifo_port_assertions #(
    parameter bit SYNC_MODE = 1'b0
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Port wire
    input wire logic txe_n,
    input wire logic rxf_n,
    input wire logic wr_n,
    input wire logic rd_n,
    input wire logic oe_n,
    input wire logic port_clk,
    input wire logic dev_data_oe,
    input wire logic host_data_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////
    a_write_gate: assert property ($fell(wr_n) |-> !txe_n)
        else $error("write strobe with transmit flag high");
    a_write_width: assert property ($fell(wr_n) |-> (!wr_n)[*5] ##1 wr_n)
        else $error("write strobe width wrong");
    a_write_taken: assert property ($fell(wr_n) |-> ##[2:5] txe_n)
        else $error("write edge not taken");
    a_read_gate: assert property ($fell(rd_n) |-> !$past(rxf_n))
        else $error("read strobe with receive flag high");
    a_read_width: assert property ($fell(rd_n) |-> (!rd_n)[*5] ##1 rd_n)
        else $error("read strobe width wrong");
    a_read_release: assert property (rd_n[*5] |-> !dev_data_oe)
        else $error("device drives bus outside read");
    a_flag_in_read: assert property ((!rd_n)[*5] |-> rxf_n)
        else $error("receive flag low during read");
    a_no_contention: assert property (!(dev_data_oe && host_data_oe))
        else $error("both ends drive the bus");
    a_clock_still: assert property (!SYNC_MODE |-> !port_clk)
        else $error("port clock toggles in async mode");
    a_enable_tracks: assert property (oe_n == rd_n)
        else $error("output enable differs from read strobe");
    c_write: cover property ($fell(wr_n));
    c_read: cover property ($fell(rd_n));
    c_full: cover property (txe_n[*8]);
endmodule // fifo_port_assertions

// file: tb/byte_wide_fifo_host_port_tb_top.sv
/*
 * Testbench joining device and host ends over the port interface.
 * Assumes a 100 MHz core clock and the valid/ready user sides.
 */
module byte_wide_fifo_host_port_tb_top
    import fifo_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, wr_ready, tx_valid, rx_ready, rd_valid;
    logic rst_b = 1'b0, clk_en = 1'b1, wr_valid = 1'b0, tx_ready = 1'b0, rx_valid = 1'b0;
    logic [DATA_W-1:0] wr_data = 8'h00, rx_data = 8'h00, tx_data, rd_data;
    logic [DATA_W-1:0] wire_wq[$], wire_rq[$];
    logic [DATA_W-1:0] rxv[4] = '{8'hff, 8'h00, 8'h81, 8'h22};
    int miscompares = 0, compares = 0;
    fifo_port_if port ();
    fifo_port_device fifo_port_device_i (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .port(port.device),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data));
    fifo_port_host fifo_port_host_i (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .port(port.host),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data));
    fifo_port_assertions fifo_port_assertions_i (.core_clk(core_clk), .rst_b(rst_b), .txe_n(port.txe_n),
        .rxf_n(port.rxf_n), .wr_n(port.wr_n), .rd_n(port.rd_n), .oe_n(port.oe_n), .port_clk(port.port_clk),
        .dev_data_oe(port.dev_data_oe), .host_data_oe(port.host_data_oe));
    ////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Wire samples; reset filter drops the x to 1 edge at start
    always @(negedge port.wr_n) wire_wq.push_back(port.port_data_lines);
    always @(posedge port.rd_n) if (rst_b === 1'b1) wire_rq.push_back(port.port_data_lines);
    task automatic chk(input string what, input logic [DATA_W-1:0] exp, got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Sampled on the falling edge, away from the design's updates
    task automatic wait_hi(ref logic sig, input string what);
        int n;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (sig !== 1'b1 && n < 200);
        chk(what, 8'h01, {7'h00, sig});
    endtask
    task automatic send(input logic [DATA_W-1:0] b);
        @(posedge core_clk);
        wr_valid <= 1'b1;
        wr_data <= b;
        wait_hi(wr_ready, "wr_ready");
        @(posedge core_clk);
        wr_valid <= 1'b0;
    endtask
    task automatic take(input logic [DATA_W-1:0] b);
        @(posedge core_clk);
        tx_ready <= 1'b1;
        wait_hi(tx_valid, "tx_valid");
        chk("tx_data", b, tx_data);
        @(posedge core_clk);
        tx_ready <= 1'b0;
    endtask
    task automatic push(input logic [DATA_W-1:0] b);
        @(posedge core_clk);
        rx_valid <= 1'b1;
        rx_data <= b;
        wait_hi(rx_ready, "rx_ready");
        @(posedge core_clk);
        rx_valid <= 1'b0;
    endtask
    task automatic recv(input logic [DATA_W-1:0] b);
        wait_hi(rd_valid, "rd_valid");
        chk("rd_data", b, rd_data);
    endtask
    task automatic end_sim;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        end_sim();
    end
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        @(negedge core_clk);
        chk("rxf_n empty", 8'h01, {7'h00, port.rxf_n});
        chk("wr_n idle", 8'h01, {7'h00, port.wr_n});
        // Far side stalls; buffer plus output stage hold one byte more than the depth
        for (int i = 0; i <= BUF_DEPTH; i++) send(8'ha0 + i[7:0]);
        repeat (20) @(negedge core_clk);
        chk("txe_n full", 8'h01, {7'h00, port.txe_n});
        fork
            send(8'h5a);
            for (int i = 0; i <= BUF_DEPTH; i++) take(8'ha0 + i[7:0]);
        join
        take(8'h5a);
        fork
            for (int i = 0; i < 3; i++) push(rxv[i]);
            for (int i = 0; i < 3; i++) recv(rxv[i]);
        join
        // Both directions at once: receive flag falls while the host is still in RD_HI, so the read goes ahead of the write
        fork
            send(8'h11);
            push(8'h22);
            recv(8'h22);
            take(8'h11);
        join
        repeat (20) @(negedge core_clk);
        for (int i = 0; i <= BUF_DEPTH; i++) chk("wr wire", 8'ha0 + i[7:0], wire_wq[i]);
        chk("wr wire", 8'h5a, wire_wq[BUF_DEPTH + 1]);
        chk("wr wire", 8'h11, wire_wq[BUF_DEPTH + 2]);
        for (int i = 0; i < 4; i++) chk("rd wire", rxv[i], wire_rq[i]);
        chk("rxf_n empty", 8'h01, {7'h00, port.rxf_n});
        chk("txe_n space", 8'h00, {7'h00, port.txe_n});
        chk("dev_data_oe", 8'h00, {7'h00, port.dev_data_oe});
        end_sim();
    end
endmodule // byte_wide_fifo_host_port_tb_top
